// >>> src/fpec_defs.vh
// register offsets, field positions and reset values for the flash program/erase control
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH
`define FPEC_OFF_MODE1 12'h000
`define FPEC_OFF_ERR2 12'h004
`define FPEC_OFF_STATUS 12'h008
`define FPEC_OFF_EMUL 12'h00C
`define FPEC_BIT_HWGATE 7
`define FPEC_BIT_SWGATE 6
`define FPEC_BIT_ERASE_SETUP 5
`define FPEC_BIT_PROGRAM_SETUP 4
`define FPEC_BIT_EVER 3
`define FPEC_BIT_PVER 2
`define FPEC_BIT_EGO 1
`define FPEC_BIT_PGO 0
`define FPEC_BIT_FLAG 7
`define FPEC_BIT_RAMSEL 0
`define FPEC_RESET_BYTE 8'h00
`define FPEC_HWGATE_BYTE 8'h80
`define FPEC_RANGE_LO 17'h00000
`define FPEC_RANGE_HI 17'h1FFFF
`endif

// >>> src/fpec_gated_bit.v
// one control bit that accepts writes only while its gate is open
`timescale 1ns/10ps
module fpec_gated_bit (
   clk,
   clr,
   wrEn,
   gate,
   forceClr,
   din,
   q
);
   input wire clk;
   input wire clr;
   input wire wrEn;
   input wire gate;
   input wire forceClr;
   input wire din;
   output reg q;

   reg q_next;

   always @* begin
      q_next = q;
      if (wrEn && gate) begin
         q_next = din;
      end
      if (forceClr) begin
         q_next = 1'b0;
      end
   end

   always @(posedge clk) begin
      if (clr) begin
         q <= 1'b0;
      end else begin
         q <= q_next;
      end
   end
endmodule // fpec_gated_bit

// >>> src/fpec_flash_ctrl.v
// flash program/erase mode control and error protection, apb slave
//
// Summary of operation
// - hardware gate bit mirrors write gate pin
// - mode register cleared by reset, standbys
// - flash disabled: mode register reads zero
// - software gate writable only with hardware gate
// - setup/verify bits need both gates set
// - erase-go needs gates and erase setup
// - program-go needs gates and program setup
// - error register resets and reads zero disabled
// - error register low bits plain storage
// - error flag blocks program and erase
// - error flag cleared by pin, watchdog, hardware standby
// - flash read during operation sets flag
// - most exceptions during operation set flag
// - sleep or bus release during operation sets flag
// - ram emulation protects all blocks
`timescale 1ns/10ps
`include "fpec_defs.vh"
module fpec_flash_ctrl (
   clk,
   rst,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   pstrb,
   prdata,
   pready,
   pslverr,
   hwGatePin,
   flashEnabled,
   hwStandby,
   swStandby,
   externalClearPin,
   watchdogReset,
   flashReadStrobe,
   ramOverlapRead,
   exceptionStart,
   exceptionExempt,
   sleepExec,
   busRelease,
   programMode,
   eraseMode,
   programSetup,
   eraseSetup,
   programVerify,
   eraseVerify,
   errorProtect,
   programEraseAllowed
);
   input wire clk;
   input wire rst;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [11:0] paddr;
   input wire [31:0] pwdata;
   input wire [3:0] pstrb;
   output reg [31:0] prdata;
   output reg pready;
   output reg pslverr;
   input wire hwGatePin;
   input wire flashEnabled;
   input wire hwStandby;
   input wire swStandby;
   input wire externalClearPin;
   input wire watchdogReset;
   input wire flashReadStrobe;
   input wire ramOverlapRead;
   input wire exceptionStart;
   input wire exceptionExempt;
   input wire sleepExec;
   input wire busRelease;
   output reg programMode;
   output reg eraseMode;
   output reg programSetup;
   output reg eraseSetup;
   output reg programVerify;
   output reg eraseVerify;
   output reg errorProtect;
   output reg programEraseAllowed;

   // ****************************************
   // bus decode
   // ****************************************
   wire setupPhase;
   wire wrAccess;
   wire rdAccess;
   wire lane0;
   wire hitMode;
   wire hitErr;
   wire hitStatus;
   wire hitEmul;
   wire hitAny;
   wire modeWr;
   assign setupPhase = psel && !penable;
   assign wrAccess = psel && penable && pready && pwrite;
   assign rdAccess = setupPhase && !pwrite;
   assign lane0 = pstrb[0];
   assign hitMode = (paddr == `FPEC_OFF_MODE1);
   assign hitErr = (paddr == `FPEC_OFF_ERR2);
   assign hitStatus = (paddr == `FPEC_OFF_STATUS);
   assign hitEmul = (paddr == `FPEC_OFF_EMUL);
   assign hitAny = hitMode || hitErr || hitStatus || hitEmul;
   assign modeWr = wrAccess && hitMode && lane0 && flashEnabled;

   // ****************************************
   // control state
   // ****************************************
   reg hwGate_reg;
   reg [6:0] errSpare_reg;
   reg flag_reg;
   reg ramSel_reg;
   reg flag_next;
   wire modeClr;
   wire flagClr;
   wire busy;
   wire swGate;
   wire eraseSetupBit;
   wire programSetupBit;
   wire ever;
   wire pver;
   wire ego;
   wire pgo;
   wire [7:0] modeByte;
   wire [7:0] errByte;

   assign modeClr = rst || hwStandby || swStandby;
   assign flagClr = externalClearPin || watchdogReset || hwStandby;
   assign busy = ego || pgo;

   // the gate pin is a synchronous input, caught every cycle
   always @(posedge clk) begin
      hwGate_reg <= hwGatePin;
   end

   fpec_gated_bit uSwGate (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg),
      .forceClr(!hwGate_reg),
      .din(pwdata[`FPEC_BIT_SWGATE]),
      .q(swGate)
   );

   fpec_gated_bit uEraseSetup (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg && swGate),
      .forceClr(!hwGate_reg),
      .din(pwdata[`FPEC_BIT_ERASE_SETUP]),
      .q(eraseSetupBit)
   );

   fpec_gated_bit uProgramSetup (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg && swGate),
      .forceClr(!hwGate_reg),
      .din(pwdata[`FPEC_BIT_PROGRAM_SETUP]),
      .q(programSetupBit)
   );

   fpec_gated_bit uEver (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg && swGate),
      .forceClr(!hwGate_reg),
      .din(pwdata[`FPEC_BIT_EVER]),
      .q(ever)
   );

   fpec_gated_bit uPver (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg && swGate),
      .forceClr(!hwGate_reg),
      .din(pwdata[`FPEC_BIT_PVER]),
      .q(pver)
   );

   // go bits: held clear under error protection or ram emulation
   fpec_gated_bit uEgo (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg && swGate && eraseSetupBit),
      .forceClr(!hwGate_reg || flag_reg || ramSel_reg),
      .din(pwdata[`FPEC_BIT_EGO]),
      .q(ego)
   );

   fpec_gated_bit uPgo (
      .clk(clk),
      .clr(modeClr),
      .wrEn(modeWr),
      .gate(hwGate_reg && swGate && programSetupBit),
      .forceClr(!hwGate_reg || flag_reg || ramSel_reg),
      .din(pwdata[`FPEC_BIT_PGO]),
      .q(pgo)
   );

   assign modeByte = {hwGate_reg, swGate, eraseSetupBit, programSetupBit, ever, pver, ego, pgo};
   assign errByte = {flag_reg, errSpare_reg};

   // ****************************************
   // error flag
   // ****************************************
   always @* begin
      flag_next = flag_reg;
      if (flagClr) begin
         flag_next = 1'b0;
      end
      if (busy && flashReadStrobe && !ramOverlapRead) begin
         flag_next = 1'b1;
      end
      if (busy && exceptionStart && !exceptionExempt) begin
         flag_next = 1'b1;
      end
      if (busy && (sleepExec || swStandby || busRelease)) begin
         flag_next = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // spare storage bits, cleared on reset and standby
   always @(posedge clk) begin
      if (modeClr) begin
         errSpare_reg <= 7'h00;
      end else if (wrAccess && hitErr && lane0 && flashEnabled) begin
         errSpare_reg <= pwdata[6:0];
      end
   end

   always @(posedge clk) begin
      if (rst || hwStandby) begin
         ramSel_reg <= 1'b0;
      end else if (wrAccess && hitEmul && lane0) begin
         ramSel_reg <= pwdata[`FPEC_BIT_RAMSEL];
      end
   end

   // ****************************************
   // apb response
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setupPhase;
         pslverr <= setupPhase && !hitAny;
         if (rdAccess) begin
            if (hitMode) begin
               prdata <= flashEnabled ? {24'h000000, modeByte} : 32'h00000000;
            end else if (hitErr) begin
               prdata <= flashEnabled ? {24'h000000, errByte} : 32'h00000000;
            end else if (hitStatus) begin
               prdata <= {24'h000000, 6'h00, busy, flag_reg};
            end else if (hitEmul) begin
               prdata <= {31'h00000000, ramSel_reg};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

   // ****************************************
   // flash-side outputs
   // ****************************************
   always @(posedge clk) begin
      if (rst) begin
         programMode <= 1'b0;
         eraseMode <= 1'b0;
         programSetup <= 1'b0;
         eraseSetup <= 1'b0;
         programVerify <= 1'b0;
         eraseVerify <= 1'b0;
         errorProtect <= 1'b0;
         programEraseAllowed <= 1'b0;
      end else begin
         programMode <= pgo && !flag_next;
         eraseMode <= ego && !flag_next;
         programSetup <= programSetupBit;
         eraseSetup <= eraseSetupBit;
         programVerify <= pver;
         eraseVerify <= ever;
         errorProtect <= flag_next;
         programEraseAllowed <= hwGate_reg && swGate && !flag_next && !ramSel_reg;
      end
   end
endmodule // fpec_flash_ctrl

// >>> bench/fpec_chk.sv
// port assertions for the flash program/erase control
`timescale 1ns/10ps
module fpec_chk (
   input logic clk,
   input logic rst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] prdata,
   input logic pready,
   input logic hwGatePin,
   input logic flashEnabled,
   input logic flashReadStrobe,
   input logic ramOverlapRead,
   input logic exceptionStart,
   input logic exceptionExempt,
   input logic sleepExec,
   input logic busRelease,
   input logic programMode,
   input logic eraseMode,
   input logic programSetup,
   input logic errorProtect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_busy;
      programMode || eraseMode;
   endsequence
   sequence s_mode_read;
      pready && !pwrite && paddr == 12'h000 && flashEnabled;
   endsequence
   a_answer_next: assert property (s_setup |=> pready)
      else $error("no answer after setup");
   a_gate_low_clears: assert property (!hwGatePin [*4] |-> !programSetup && !programMode)
      else $error("mode bits set with gate low");
   a_go_after_setup: assert property ($rose(programMode) |-> $past(programSetup))
      else $error("program go without setup");
   a_read_flags: assert property (s_busy ##0 (flashReadStrobe && !ramOverlapRead) |-> ##[1:2] errorProtect)
      else $error("flash read did not flag");
   a_exc_flags: assert property (s_busy ##0 (exceptionStart && !exceptionExempt) |-> ##[1:2] errorProtect)
      else $error("exception did not flag");
   a_sleep_flags: assert property (s_busy ##0 (sleepExec || busRelease) |-> ##[1:2] errorProtect)
      else $error("sleep or release did not flag");
   a_protect_clears: assert property (errorProtect [*3] ##0 s_mode_read |-> prdata[1:0] == 2'b00)
      else $error("go bits alive under protection");
   a_disabled_zero: assert property (pready && !pwrite && !flashEnabled && paddr < 12'h008 |-> prdata == 32'h0)
      else $error("disabled read not zero");
endmodule // fpec_chk
bind fpec_flash_ctrl fpec_chk chk (.*);

// >>> bench/fpec_cpu_model.sv
// cpu and bus controller events toward the flash control
`timescale 1ns/10ps
module fpec_cpu_model (
   input wire logic clk,
   input wire logic [2:0] evCode,
   input wire logic evGo,
   output logic flashReadStrobe,
   output logic ramOverlapRead,
   output logic exceptionStart,
   output logic exceptionExempt,
   output logic sleepExec,
   output logic busRelease
);
   // events only when commanded
   always @(posedge clk) begin
      flashReadStrobe <= evGo && evCode < 3'h2;
      ramOverlapRead <= evGo && evCode == 3'h1;
      exceptionStart <= evGo && evCode[2:1] == 2'h1;
      exceptionExempt <= evGo && evCode == 3'h3;
      sleepExec <= evGo && evCode == 3'h4;
      busRelease <= evGo && evCode == 3'h5;
   end
endmodule // fpec_cpu_model

// >>> bench/fpec_flash_ctrl_bench.sv
// self-checking testbench for the flash program/erase control
`timescale 1ns/10ps
module fpec_flash_ctrl_bench;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, evGo = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'h1;
   logic [2:0] evCode = 3'h0;
   logic hwGatePin = 1, flashEnabled = 1, hwStandby = 0, swStandby = 0;
   logic externalClearPin = 0, watchdogReset = 0, er;
   logic pready, pslverr, programMode, eraseMode, programSetup, eraseSetup;
   logic programVerify, eraseVerify, errorProtect, programEraseAllowed;
   logic flashReadStrobe, ramOverlapRead, exceptionStart, exceptionExempt, sleepExec, busRelease;
   logic [7:0] rd;
   logic [7:0] pins;
   logic [27:0] rows [14];
   integer fail_count = 0, num_checks = 0, i;
   fpec_flash_ctrl DUT (.*);
   fpec_cpu_model cpu (.*);
   assign pins = {programEraseAllowed, errorProtect, eraseSetup, programSetup,
      eraseVerify, programVerify, eraseMode, programMode};
   always #10 clk = ~clk;
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      integer n;
      psel <= 1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         end_of_test;
      end
      rd = prdata[7:0];
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task rdx(input logic [11:0] a, input logic [7:0] exp);
      apb(a, 0, 8'h00);
      chk(rd, exp);
   endtask
   task fire(input logic [2:0] c);
      evCode <= c;
      evGo <= 1;
      @(posedge clk);
      evGo <= 0;
      repeat (3) @(posedge clk);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      rows = '{{12'h000, 8'h3F, 8'h80}, {12'h000, 8'h40, 8'hC0}, {12'h000, 8'h41, 8'hC0},
         {12'h000, 8'h50, 8'hD0}, {12'h000, 8'h51, 8'hD1}, {12'h000, 8'h42, 8'hC0},
         {12'h000, 8'h60, 8'hE0}, {12'h000, 8'h62, 8'hE2}, {12'h000, 8'h48, 8'hC8},
         {12'h000, 8'h44, 8'hC4}, {12'h004, 8'hFF, 8'h7F}, {12'h00C, 8'h01, 8'h01},
         {12'h000, 8'h50, 8'hD0}, {12'h000, 8'h51, 8'hD0}};
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      for (i = 0; i < 14; i++) begin
         apb(rows[i][27:16], 1, rows[i][15:8]);
         rdx(rows[i][27:16], rows[i][7:0]);
         if (rows[i][27:16] == 12'h000) begin
            chk(pins, {rows[i][7] && rows[i][6] && i < 11, 1'b0, rows[i][5:0]});
         end
      end
      hwStandby <= 1;
      @(posedge clk);
      hwStandby <= 0;
      rdx(12'h000, 8'h80);
      rdx(12'h004, 8'h00);
      hwGatePin <= 0;
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      apb(12'h000, 1, 8'h40);
      rdx(12'h000, 8'h00);
      hwGatePin <= 1;
      apb(12'h004, 1, 8'h11);
      flashEnabled <= 0;
      rdx(12'h000, 8'h00);
      apb(12'h004, 1, 8'h22);
      rdx(12'h004, 8'h00);
      flashEnabled <= 1;
      rdx(12'h004, 8'h11);
      for (i = 0; i < 6; i++) begin
         apb(12'h000, 1, 8'h40);
         apb(12'h000, 1, 8'h50);
         apb(12'h000, 1, 8'h51);
         fire(i[2:0]);
         apb(12'h000, 1, 8'h51);
         rdx(12'h004, {i != 1 && i != 3, 7'h11});
         rdx(12'h000, {7'h68, i == 1 || i == 3});
         rdx(12'h008, (i == 1 || i == 3) ? 8'h02 : 8'h01);
         chk(pins, (i == 1 || i == 3) ? 8'h91 : 8'h50);
         externalClearPin <= 1;
         @(posedge clk);
         externalClearPin <= 0;
         apb(12'h000, 1, 8'h00);
      end
      apb(12'h000, 1, 8'h40);
      apb(12'h000, 1, 8'h60);
      apb(12'h000, 1, 8'h62);
      fire(3'h0);
      swStandby <= 1;
      @(posedge clk);
      swStandby <= 0;
      rdx(12'h004, 8'h80);
      watchdogReset <= 1;
      @(posedge clk);
      watchdogReset <= 0;
      rdx(12'h004, 8'h00);
      apb(12'h000, 1, 8'h40);
      apb(12'h000, 1, 8'h50);
      apb(12'h000, 1, 8'h51);
      hwGatePin <= 0;
      repeat (4) @(posedge clk);
      chk(pins, 8'h00);
      rdx(12'h000, 8'h00);
      hwGatePin <= 1;
      apb(12'h010, 0, 8'h00);
      chk({7'h0, er}, 8'h01);
      end_of_test;
   end
endmodule // fpec_flash_ctrl_bench
